// File: core/pmic_ctrl_irq_regs.svh
`ifndef PMIC_CTRL_IRQ_REGS_SVH
`define PMIC_CTRL_IRQ_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_REG6_ACT 8'h45
`define ADDR_REG6_SLP 8'h46
`define ADDR_REG7_ACT 8'h47
`define ADDR_REG7_SLP 8'h48
`define ADDR_REG8_ACT 8'h49
`define ADDR_REG8_SLP 8'h4a
`define ADDR_DEV_CTRL 8'h4b
`define ADDR_STS_ONE 8'h4c
`define ADDR_MSK_ONE 8'h4d
`define ADDR_STS_TWO 8'h4e
`define ADDR_MSK_TWO 8'h4f
`define ADDR_PIN_POL 8'h50
`define ADDR_BUCK_ILIM 8'h90

// ----------------------------------------------------------------
// Field widths, positions and reset values
// ----------------------------------------------------------------
`define VCODE_W 5
`define STS_ONE_W 7
`define STS_TWO_W 2
`define POL_W 3
`define SYNC_W 4
`define RST_SLEEP_CODE 5'h00
`define RST_STS_ONE 7'h00
`define RST_STS_TWO 2'h0
`define RST_POL 3'h6
`define RST_ILIM 8'h55
`define CTL_OFF_BIT 0
`define CTL_SLP_BIT 1
`define CTL_OFFRST_BIT 3
`define CTL_HOLD_LSB 4
`define POL_IRQ_BIT 0
`define POL_A_BIT 1
`define POL_B_BIT 2
`define EV_OUT_LOW 0
`define EV_BAT_LOW 1
`define EV_BUTTON 2
`define EV_LONG_PRESS 3
`define EV_OVERTEMP 4
`define EV_ALARM 5
`define EV_PERIOD 6
`define EV_CHG_IN 0
`define EV_CHG_OUT 1
`define PIN_CHARGER 0
`define PIN_BUTTON 1
`define PIN_SCALE_A 2
`define PIN_SCALE_B 3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SEC_NS 1000000000
`define CLK_NS 4
`define SEC_CYCLES (`SEC_NS / `CLK_NS)
`define TICK_W 28
`define SEC_CNT_W 4
`define HOLD_BASE_S 6
`define HOLD_STEP_S 2

`endif

// File: core/pmic_ctrl_irq_pkg.sv
`include "pmic_ctrl_irq_regs.svh"

package pmic_ctrl_irq_pkg;

   typedef enum logic [1:0] {ST_OFF, ST_ACTIVE, ST_SLEEP} dev_state_t;

   typedef logic [`VCODE_W-1:0] vcode_t;

   typedef struct packed {
      dev_state_t state;
      vcode_t r6_act;
      vcode_t r6_slp;
      vcode_t r7_act;
      vcode_t r7_slp;
      vcode_t r8_act;
      vcode_t r8_slp;
      logic [1:0] hold_time;
      logic off_rst;
      logic sleep_req;
      logic off_req;
      logic [`STS_ONE_W-1:0] sts1;
      logic [`STS_ONE_W-1:0] msk1;
      logic [`STS_TWO_W-1:0] sts2;
      logic [`STS_TWO_W-1:0] msk2;
      logic [`POL_W-1:0] pol;
      logic [7:0] ilim;
      logic [7:0] rdata;
      logic rvalid;
      logic irq_pin;
      logic scale_a;
      logic scale_b;
      logic core_reset;
      logic chg_prev;
      logic btn_prev;
      logic [`TICK_W-1:0] tick_cnt;
      logic [`SEC_CNT_W-1:0] sec_cnt;
   } ctrl_state_t;

   typedef struct packed {
      logic [`SYNC_W-1:0] st1;
      logic [`SYNC_W-1:0] st2;
      logic [`SYNC_W-1:0] st3;
      logic [`SYNC_W-1:0] lvl;
   } sync_state_t;

endpackage

// File: core/pin_sync.sv
`include "pmic_ctrl_irq_regs.svh"

module pin_sync (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [`SYNC_W-1:0] pin_raw,
   output logic [`SYNC_W-1:0] pin_level
);
   import pmic_ctrl_irq_pkg::*;

   sync_state_t s_q;
   sync_state_t s_d;
   logic [`SYNC_W-1:0] agree;

   // ----------------------------------------------------------------
   // Three stages; a change counts once stages two and three agree
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      agree = ~(s_q.st2 ^ s_q.st3);
      s_d.st1 = pin_raw;
      s_d.st2 = s_q.st1;
      s_d.st3 = s_q.st2;
      s_d.lvl = (agree & s_q.st3) | (~agree & s_q.lvl);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pin_level = s_q.lvl;

endmodule

// File: core/pmic_ctrl_irq_regs.sv
`include "pmic_ctrl_irq_regs.svh"

module pmic_ctrl_irq_regs #(
   parameter int unsigned TICK_CYCLES = `SEC_CYCLES
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire pmic_ctrl_irq_pkg::vcode_t strap_reg6_code,
   input wire pmic_ctrl_irq_pkg::vcode_t strap_reg7_code,
   input wire pmic_ctrl_irq_pkg::vcode_t strap_reg8_code,
   input wire logic [`STS_ONE_W-1:0] event_pulse,
   input wire logic charger_present_status,
   input wire logic button_pin,
   input wire logic scale_pin_a,
   input wire logic scale_pin_b,
   output pmic_ctrl_irq_pkg::vcode_t reg6_active_code,
   output pmic_ctrl_irq_pkg::vcode_t reg6_sleep_code,
   output pmic_ctrl_irq_pkg::vcode_t reg7_active_code,
   output pmic_ctrl_irq_pkg::vcode_t reg7_sleep_code,
   output pmic_ctrl_irq_pkg::vcode_t reg8_active_code,
   output pmic_ctrl_irq_pkg::vcode_t reg8_sleep_code,
   output logic [1:0] button_hold_off_time,
   output logic [1:0] conv1_current_limit,
   output logic [1:0] conv2_current_limit,
   output logic [1:0] conv3_current_limit,
   output logic [1:0] conv4_current_limit,
   output pmic_ctrl_irq_pkg::dev_state_t device_state,
   output logic core_reset,
   output logic irq_pin,
   output logic scale_a_active,
   output logic scale_b_active
);
   import pmic_ctrl_irq_pkg::*;

   localparam logic [`TICK_W-1:0] TICK_LAST = `TICK_W'(TICK_CYCLES - 1);

   ctrl_state_t s_q;
   ctrl_state_t s_d;
   ctrl_state_t s_rst;
   logic [`SYNC_W-1:0] pins;
   logic btn;
   logic chg;
   logic tick;
   logic long_press;
   logic pend;
   logic [`STS_ONE_W-1:0] ev1;
   logic [`STS_TWO_W-1:0] ev2;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic wr_at(input logic [7:0] a);
      return reg_wr && (reg_addr == a);
   endfunction

   function automatic logic [`SEC_CNT_W-1:0] hold_secs(input logic [1:0] code);
      return `SEC_CNT_W'(`HOLD_BASE_S + `HOLD_STEP_S * code);
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   pin_sync u_sync (
      .ref_clk(ref_clk),
      .srst(srst),
      .pin_raw({scale_pin_b, scale_pin_a, button_pin, charger_present_status}),
      .pin_level(pins)
   );

   assign btn = pins[`PIN_BUTTON];
   assign chg = pins[`PIN_CHARGER];
   assign tick = (s_q.tick_cnt == TICK_LAST);
   assign long_press = btn && tick && (s_q.state != ST_OFF)
      && (s_q.sec_cnt + `SEC_CNT_W'(1) == hold_secs(s_q.hold_time));
   assign pend = |(s_q.sts1 & ~s_q.msk1) | |(s_q.sts2 & ~s_q.msk2);

   // ----------------------------------------------------------------
   // Reset values; active codes come from the boot straps
   // ----------------------------------------------------------------
   always_comb begin
      s_rst = '0;
      s_rst.state = ST_ACTIVE;
      s_rst.r6_act = strap_reg6_code;
      s_rst.r7_act = strap_reg7_code;
      s_rst.r8_act = strap_reg8_code;
      s_rst.r6_slp = `RST_SLEEP_CODE;
      s_rst.r7_slp = `RST_SLEEP_CODE;
      s_rst.r8_slp = `RST_SLEEP_CODE;
      s_rst.sts1 = `RST_STS_ONE;
      s_rst.sts2 = `RST_STS_TWO;
      s_rst.pol = `RST_POL;
      s_rst.ilim = `RST_ILIM;
      s_rst.irq_pin = 1'b1;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.core_reset = 1'b0;
      s_d.chg_prev = chg;
      s_d.btn_prev = btn;

      // Register writes
      if (wr_at(`ADDR_REG6_ACT)) s_d.r6_act = reg_wdata[`VCODE_W-1:0];
      if (wr_at(`ADDR_REG6_SLP)) s_d.r6_slp = reg_wdata[`VCODE_W-1:0];
      if (wr_at(`ADDR_REG7_ACT)) s_d.r7_act = reg_wdata[`VCODE_W-1:0];
      if (wr_at(`ADDR_REG7_SLP)) s_d.r7_slp = reg_wdata[`VCODE_W-1:0];
      if (wr_at(`ADDR_REG8_ACT)) s_d.r8_act = reg_wdata[`VCODE_W-1:0];
      if (wr_at(`ADDR_REG8_SLP)) s_d.r8_slp = reg_wdata[`VCODE_W-1:0];
      if (wr_at(`ADDR_DEV_CTRL)) begin
         s_d.hold_time = reg_wdata[`CTL_HOLD_LSB +: 2];
         s_d.off_rst = reg_wdata[`CTL_OFFRST_BIT];
         s_d.sleep_req = reg_wdata[`CTL_SLP_BIT];
         s_d.off_req = reg_wdata[`CTL_OFF_BIT];
      end
      if (wr_at(`ADDR_MSK_ONE)) s_d.msk1 = reg_wdata[`STS_ONE_W-1:0];
      if (wr_at(`ADDR_MSK_TWO)) s_d.msk2 = reg_wdata[`STS_TWO_W-1:0];
      if (wr_at(`ADDR_PIN_POL)) s_d.pol = reg_wdata[`POL_W-1:0];
      if (wr_at(`ADDR_BUCK_ILIM)) s_d.ilim = reg_wdata;

      // Write-one clears first, then new events, so a set wins
      if (wr_at(`ADDR_STS_ONE)) s_d.sts1 = s_q.sts1 & ~reg_wdata[`STS_ONE_W-1:0];
      if (wr_at(`ADDR_STS_TWO)) s_d.sts2 = s_q.sts2 & ~reg_wdata[`STS_TWO_W-1:0];
      ev1 = event_pulse;
      ev1[`EV_BUTTON] = event_pulse[`EV_BUTTON] | (btn & ~s_q.btn_prev);
      ev1[`EV_LONG_PRESS] = event_pulse[`EV_LONG_PRESS] | long_press;
      ev2 = '0;
      ev2[`EV_CHG_IN] = chg & ~s_q.chg_prev;
      ev2[`EV_CHG_OUT] = ~chg & s_q.chg_prev;
      s_d.sts1 = s_d.sts1 | ev1;
      s_d.sts2 = s_d.sts2 | ev2;

      // Register reads, reserved and unmapped bits read zero
      if (reg_rd) begin
         s_d.rvalid = 1'b1;
         unique case (reg_addr)
            `ADDR_REG6_ACT: s_d.rdata = {3'h0, s_q.r6_act};
            `ADDR_REG6_SLP: s_d.rdata = {3'h0, s_q.r6_slp};
            `ADDR_REG7_ACT: s_d.rdata = {3'h0, s_q.r7_act};
            `ADDR_REG7_SLP: s_d.rdata = {3'h0, s_q.r7_slp};
            `ADDR_REG8_ACT: s_d.rdata = {3'h0, s_q.r8_act};
            `ADDR_REG8_SLP: s_d.rdata = {3'h0, s_q.r8_slp};
            `ADDR_DEV_CTRL: s_d.rdata = {2'h0, s_q.hold_time, s_q.off_rst, 1'b0,
                                         s_q.sleep_req, s_q.off_req};
            `ADDR_STS_ONE: s_d.rdata = {1'b0, s_q.sts1};
            `ADDR_MSK_ONE: s_d.rdata = {1'b0, s_q.msk1};
            `ADDR_STS_TWO: s_d.rdata = {6'h00, s_q.sts2};
            `ADDR_MSK_TWO: s_d.rdata = {6'h00, s_q.msk2};
            `ADDR_PIN_POL: s_d.rdata = {5'h00, s_q.pol};
            `ADDR_BUCK_ILIM: s_d.rdata = s_q.ilim;
            default: s_d.rdata = 8'h00;
         endcase
      end

      // Button hold timer, one-second enable pulses
      if (!btn || s_q.state == ST_OFF) begin
         s_d.tick_cnt = '0;
         s_d.sec_cnt = '0;
      end else if (tick) begin
         s_d.tick_cnt = '0;
         if (s_q.sec_cnt != hold_secs(s_q.hold_time)) begin
            s_d.sec_cnt = s_q.sec_cnt + `SEC_CNT_W'(1);
         end
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + `TICK_W'(1);
      end

      // Device state
      unique case (s_q.state)
         ST_OFF: begin
            s_d.sleep_req = 1'b0;
            s_d.off_req = 1'b0;
            s_d.off_rst = 1'b0;
            if (btn && !s_q.btn_prev) begin
               s_d.state = ST_ACTIVE;
            end
         end
         ST_ACTIVE, ST_SLEEP: begin
            if (s_d.off_rst || s_d.off_req || long_press) begin
               s_d.state = ST_OFF;
               s_d.core_reset = s_d.off_rst;
            end else if (s_d.sleep_req) begin
               s_d.state = ST_SLEEP;
            end else begin
               s_d.state = ST_ACTIVE;
            end
         end
         // Unused state code falls back to off
         default: s_d.state = ST_OFF;
      endcase

      // Pins with their polarity
      s_d.irq_pin = ~(pend ^ s_q.pol[`POL_IRQ_BIT]);
      s_d.scale_a = ~(pins[`PIN_SCALE_A] ^ s_q.pol[`POL_A_BIT]);
      s_d.scale_b = ~(pins[`PIN_SCALE_B] ^ s_q.pol[`POL_B_BIT]);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_q <= s_rst;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata = s_q.rdata;
   assign reg_rvalid = s_q.rvalid;
   assign reg6_active_code = s_q.r6_act;
   assign reg6_sleep_code = s_q.r6_slp;
   assign reg7_active_code = s_q.r7_act;
   assign reg7_sleep_code = s_q.r7_slp;
   assign reg8_active_code = s_q.r8_act;
   assign reg8_sleep_code = s_q.r8_slp;
   assign button_hold_off_time = s_q.hold_time;
   assign conv1_current_limit = s_q.ilim[1:0];
   assign conv2_current_limit = s_q.ilim[3:2];
   assign conv3_current_limit = s_q.ilim[5:4];
   assign conv4_current_limit = s_q.ilim[7:6];
   assign device_state = s_q.state;
   assign core_reset = s_q.core_reset;
   assign irq_pin = s_q.irq_pin;
   assign scale_a_active = s_q.scale_a;
   assign scale_b_active = s_q.scale_b;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   a_sleep_entry: assert property (
      s_q.state == ST_ACTIVE && wr_at(`ADDR_DEV_CTRL) && reg_wdata[`CTL_SLP_BIT]
      && !reg_wdata[`CTL_OFF_BIT] && !reg_wdata[`CTL_OFFRST_BIT] && !long_press
      |=> s_q.state == ST_SLEEP)
      else $error("sleep not entered");

   a_wake_exit: assert property (
      s_q.state == ST_SLEEP && wr_at(`ADDR_DEV_CTRL) && reg_wdata[3:0] == 4'h0
      && !long_press |=> s_q.state == ST_ACTIVE)
      else $error("wake-up not taken");

   a_off_clears: assert property (
      s_q.state == ST_OFF ##1 s_q.state == ST_OFF |-> !s_q.sleep_req && !s_q.off_req)
      else $error("control bits held in off");

   a_off_entry: assert property (
      s_q.state != ST_OFF && wr_at(`ADDR_DEV_CTRL) && reg_wdata[`CTL_OFF_BIT]
      && !reg_wdata[`CTL_OFFRST_BIT] |=> s_q.state == ST_OFF && !core_reset)
      else $error("switch-off not taken");

   a_core_reset: assert property (
      s_q.state != ST_OFF && wr_at(`ADDR_DEV_CTRL) && reg_wdata[`CTL_OFFRST_BIT]
      |=> core_reset && s_q.state == ST_OFF ##1 !core_reset)
      else $error("core reset pulse wrong");

   a_w1c_clear: assert property (
      wr_at(`ADDR_STS_ONE) && reg_wdata[`EV_OUT_LOW] && !event_pulse[`EV_OUT_LOW]
      |=> !s_q.sts1[`EV_OUT_LOW])
      else $error("status not cleared");

   a_w0_keep: assert property (
      s_q.sts1[`EV_ALARM] && !(wr_at(`ADDR_STS_ONE) && reg_wdata[`EV_ALARM])
      |=> s_q.sts1[`EV_ALARM])
      else $error("status lost without clear");

   a_set_wins: assert property (
      event_pulse[`EV_OVERTEMP] |=> s_q.sts1[`EV_OVERTEMP])
      else $error("event not latched");

   a_charger_edge: assert property (
      chg && !s_q.chg_prev |=> s_q.sts2[`EV_CHG_IN] ##1 s_q.sts2[`EV_CHG_IN]
      || $past(wr_at(`ADDR_STS_TWO)))
      else $error("charger insertion missed");

   a_irq_level: assert property (
      ##1 1'b1 |-> irq_pin == ~($past(pend) ^ $past(s_q.pol[`POL_IRQ_BIT])))
      else $error("interrupt pin level wrong");

   a_irq_idle: assert property (
      (s_q.sts1 & ~s_q.msk1) == '0 && (s_q.sts2 & ~s_q.msk2) == '0
      |=> irq_pin == !$past(s_q.pol[`POL_IRQ_BIT]))
      else $error("interrupt pin active with nothing pending");

   a_irq_one: assert property (
      (s_q.sts1 & ~s_q.msk1) != '0
      |=> irq_pin == $past(s_q.pol[`POL_IRQ_BIT]))
      else $error("first status event not signalled");

   a_irq_two: assert property (
      (s_q.sts2 & ~s_q.msk2) != '0
      |=> irq_pin == $past(s_q.pol[`POL_IRQ_BIT]))
      else $error("charger event not signalled");

   a_scale_a_level: assert property (
      1'b1 |=> scale_a_active == ($past(s_q.pol[`POL_A_BIT]) ?
      $past(pins[`PIN_SCALE_A]) : !$past(pins[`PIN_SCALE_A])))
      else $error("scaling pin a polarity wrong");

   a_scale_b_level: assert property (
      1'b1 |=> scale_b_active == ($past(s_q.pol[`POL_B_BIT]) ?
      $past(pins[`PIN_SCALE_B]) : !$past(pins[`PIN_SCALE_B])))
      else $error("scaling pin b polarity wrong");

   a_reset_values: assert property (
      $past(srst) |-> s_q.r6_slp == '0 && s_q.r7_slp == '0 && s_q.r8_slp == '0
      && s_q.msk1 == '0 && s_q.pol == `RST_POL && s_q.ilim == `RST_ILIM)
      else $error("reset values wrong");

   a_strap_load: assert property (
      $past(srst) |-> s_q.r6_act == $past(strap_reg6_code)
      && s_q.r7_act == $past(strap_reg7_code) && s_q.r8_act == $past(strap_reg8_code))
      else $error("strap codes not loaded");

   a_long_press: assert property (
      long_press |=> s_q.state == ST_OFF && s_q.sts1[`EV_LONG_PRESS])
      else $error("long press not handled");

   a_charger_fall: assert property (
      !chg && s_q.chg_prev |=> s_q.sts2[`EV_CHG_OUT])
      else $error("charger removal missed");

endmodule

// File: verification/host_model.sv
module host_model (
   input wire logic ref_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // ---------------------------------------------------------------
   // One byte access; strobe lasts one rising edge
   // ---------------------------------------------------------------
   // Idle address and data show the inverse of the last access
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(negedge ref_clk);
      reg_wr = wr;
      reg_rd = ~wr;
      reg_addr = addr;
      reg_wdata = data;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~addr;
      reg_wdata = ~data;
   endtask
endmodule

// File: verification/testbench.sv
`include "pmic_ctrl_irq_regs.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pmic_ctrl_irq_pkg::*;

   localparam int TICKS = 10;
   localparam logic [7:0] WA [10] = '{8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h4d, 8'h4f,
      8'h50, 8'h90};
   localparam logic [7:0] WM [10] = '{8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h7f, 8'h03,
      8'h07, 8'hff};

   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr, reg_rd, reg_rvalid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   vcode_t strap_reg6_code = '0, strap_reg7_code = '0, strap_reg8_code = '0;
   logic [`STS_ONE_W-1:0] event_pulse = '0;
   logic charger_present_status = 1'b0, button_pin = 1'b0;
   logic scale_pin_a = 1'b0, scale_pin_b = 1'b0;
   vcode_t reg6_active_code, reg6_sleep_code, reg7_active_code, reg7_sleep_code;
   vcode_t reg8_active_code, reg8_sleep_code;
   logic [1:0] button_hold_off_time, conv1_current_limit, conv2_current_limit;
   logic [1:0] conv3_current_limit, conv4_current_limit;
   dev_state_t device_state;
   logic core_reset, irq_pin, scale_a_active, scale_b_active;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [7:0] exp_q [$];
   logic [7:0] wd [10];

   always #2 ref_clk = ~ref_clk;

   host_model u_host_model (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

   pmic_ctrl_irq_regs #(.TICK_CYCLES(TICKS)) u_pmic_ctrl_irq_regs (
      .ref_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
      .strap_reg6_code, .strap_reg7_code, .strap_reg8_code, .event_pulse,
      .charger_present_status, .button_pin, .scale_pin_a, .scale_pin_b,
      .reg6_active_code, .reg6_sleep_code, .reg7_active_code, .reg7_sleep_code,
      .reg8_active_code, .reg8_sleep_code, .button_hold_off_time,
      .conv1_current_limit, .conv2_current_limit, .conv3_current_limit,
      .conv4_current_limit, .device_state, .core_reset, .irq_pin,
      .scale_a_active, .scale_b_active);

   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Read answers are matched against the oldest noted expectation
   always @(negedge ref_clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(reg_rdata, 8'hxx);
         end else begin
            check(reg_rdata, exp_q.pop_front());
         end
      end
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         end_of_test();
      end
   end

   // ---------------------------------------------------------------
   // Access helpers
   // ---------------------------------------------------------------
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host_model.access(1'b0, a, 8'h00);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host_model.access(1'b1, a, d);
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Event pulse for one edge, then wait until the pin has followed
   task automatic pulse(input int b);
      @(negedge ref_clk);
      event_pulse = 7'(1 << b);
      wait_n(1);
      event_pulse = '0;
      wait_n(2);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(1));
      strap_reg6_code = 5'($urandom_range(17));
      strap_reg7_code = 5'($urandom_range(17));
      strap_reg8_code = 5'($urandom_range(16));
      scale_pin_a = 1'($urandom);
      scale_pin_b = 1'($urandom);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      srst = 1'b0;

      rd(`ADDR_REG6_ACT, {3'h0, strap_reg6_code});
      rd(`ADDR_REG7_ACT, {3'h0, strap_reg7_code});
      rd(`ADDR_REG8_ACT, {3'h0, strap_reg8_code});
      for (int a = 8'h46; a <= 8'h4a; a += 2) rd(8'(a), 8'h00);
      for (int a = 8'h4b; a <= 8'h4f; a++) rd(8'(a), 8'h00);
      rd(`ADDR_PIN_POL, 8'h06);
      rd(`ADDR_BUCK_ILIM, 8'h55);
      rd(8'h51, 8'h00);
      check(irq_pin, 1'b1);

      for (int i = 0; i < 10; i++) begin
         wd[i] = 8'($urandom);
         if (i < 6) wd[i][4:0] = 5'($urandom_range(i < 4 ? 17 : 16));
         wr(WA[i], wd[i]);
         rd(WA[i], wd[i] & WM[i]);
      end
      check(reg6_active_code, wd[0][4:0]);
      check(reg6_sleep_code, wd[1][4:0]);
      check(reg7_active_code, wd[2][4:0]);
      check(reg7_sleep_code, wd[3][4:0]);
      check(reg8_active_code, wd[4][4:0]);
      check(reg8_sleep_code, wd[5][4:0]);
      check({conv4_current_limit, conv3_current_limit, conv2_current_limit,
         conv1_current_limit}, wd[9]);
      check(scale_a_active, wd[8][1] ? scale_pin_a : !scale_pin_a);
      check(scale_b_active, wd[8][2] ? scale_pin_b : !scale_pin_b);
      wr(`ADDR_MSK_ONE, 8'h00);
      wr(`ADDR_MSK_TWO, 8'h00);
      wr(`ADDR_PIN_POL, 8'h06);
      scale_pin_a = ~scale_pin_a;
      wait_n(8);
      check(scale_a_active, scale_pin_a);

      for (int b = 0; b < 7; b++) begin
         pulse(b);
         check(irq_pin, 1'b0);
         wr(`ADDR_STS_ONE, 8'h00);
         rd(`ADDR_STS_ONE, 8'(1 << b));
         wr(`ADDR_STS_ONE, 8'(1 << b));
         rd(`ADDR_STS_ONE, 8'h00);
         check(irq_pin, 1'b1);
         wr(`ADDR_MSK_ONE, 8'(1 << b));
         pulse(b);
         check(irq_pin, 1'b1);
         wr(`ADDR_MSK_ONE, 8'h00);
         wait_n(1);
         check(irq_pin, 1'b0);
         wr(`ADDR_STS_ONE, 8'(1 << b));
      end
      wr(`ADDR_PIN_POL, 8'h07);
      wait_n(1);
      check(irq_pin, 1'b0);
      pulse(0);
      check(irq_pin, 1'b1);
      wr(`ADDR_STS_ONE, 8'h01);
      wr(`ADDR_PIN_POL, 8'h06);
      // Event and its clear on the same edge: the event must stay latched
      fork
         wr(`ADDR_STS_ONE, 8'h01);
         pulse(0);
      join
      rd(`ADDR_STS_ONE, 8'h01);
      wr(`ADDR_STS_ONE, 8'h01);

      charger_present_status = 1'b1;
      wait_n(10);
      rd(`ADDR_STS_TWO, 8'h01);
      check(irq_pin, 1'b0);
      wr(`ADDR_STS_TWO, 8'h01);
      wr(`ADDR_MSK_TWO, 8'h02);
      charger_present_status = 1'b0;
      wait_n(10);
      rd(`ADDR_STS_TWO, 8'h02);
      check(irq_pin, 1'b1);
      wr(`ADDR_STS_TWO, 8'h02);
      wr(`ADDR_MSK_TWO, 8'h00);

      wr(`ADDR_DEV_CTRL, 8'h02);
      check(device_state, ST_SLEEP);
      rd(`ADDR_DEV_CTRL, 8'h02);
      wr(`ADDR_DEV_CTRL, 8'h00);
      check(device_state, ST_ACTIVE);
      wr(`ADDR_DEV_CTRL, 8'h13);
      check(device_state, ST_OFF);
      check(core_reset, 1'b0);
      check(button_hold_off_time, 2'b01);
      rd(`ADDR_DEV_CTRL, 8'h10);

      button_pin = 1'b1;
      wait_n(70);
      check(device_state, ST_ACTIVE);
      wait_n(25);
      check(device_state, ST_OFF);
      button_pin = 1'b0;
      rd(`ADDR_STS_ONE, 8'h0c);
      wr(`ADDR_STS_ONE, 8'h0c);
      button_pin = 1'b1;
      wait_n(8);
      button_pin = 1'b0;
      wait_n(2);
      wr(`ADDR_DEV_CTRL, 8'h08);
      check(device_state, ST_OFF);
      check(core_reset, 1'b1);
      wait_n(1);
      check(core_reset, 1'b0);
      wait_n(4);
      check(8'(exp_q.size()), 8'h00);
      end_of_test();
   end
endmodule
